/* File: bench/rscl_assertions.sv */
`timescale 1ns/1ps
// Strap latch and bus checks, from the top-level ports only
module rscl_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // Bus
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Captured configuration and reset event pulses
  input wire logic       config_valid_r,
  input wire logic       sw_mode_r,
  input wire logic [1:0] range_code_r,
  input wire logic       int_ref_en_r,
  input wire logic       serial_if_r,
  input wire logic       serial_one_wire_r,
  input wire logic       full_reset_pulse_r,
  input wire logic       partial_reset_pulse_r,
  // Feature enables
  input wire logic       feat_per_chan_r,
  input wire logic       feat_unified_r,
  input wire logic       feat_full_seq_r,
  input wire logic       feat_diag_r,
  input wire logic       feat_reg_access_r,
  input wire logic       feat_oversample_r,
  input wire logic       feat_one_wire_r,
  input wire logic       feat_two_wire_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Capture moments
  chk_valid_set: assert property (full_reset_pulse_r |-> config_valid_r)
    else $error("valid not set at capture");
  chk_mode_decode: assert property (full_reset_pulse_r |->
    sw_mode_r == (range_code_r == 2'h0))
    else $error("mode does not match range code");
  chk_mode_fixed: assert property ($changed(sw_mode_r) |-> full_reset_pulse_r)
    else $error("mode changed without full reset");
  chk_straps_fixed: assert property (
    $changed({int_ref_en_r, serial_if_r, serial_one_wire_r}) |-> full_reset_pulse_r)
    else $error("strap latch changed without full reset");
  chk_pulse_single: assert property (full_reset_pulse_r |=> !full_reset_pulse_r)
    else $error("full reset pulse too long");
  chk_reset_kinds: assert property (!(full_reset_pulse_r && partial_reset_pulse_r))
    else $error("full and partial together");
  // Feature matrix one cycle after capture
  chk_feat_gate: assert property (full_reset_pulse_r |=>
    {feat_per_chan_r, feat_full_seq_r, feat_diag_r, feat_reg_access_r, feat_unified_r} ==
    {{4{sw_mode_r}}, !sw_mode_r})
    else $error("feature gate wrong");
  chk_feat_osmp: assert property (full_reset_pulse_r |=>
    feat_oversample_r == (sw_mode_r || serial_if_r))
    else $error("oversampling gate wrong");
  chk_feat_wire: assert property (full_reset_pulse_r |=>
    feat_one_wire_r == serial_if_r && feat_two_wire_r == serial_if_r)
    else $error("serial wire gate wrong");
  // Bus answers
  chk_hw_refuse: assert property (!avs_waitrequest && !sw_mode_r |-> avs_response == 2'h2)
    else $error("access accepted outside software mode");
  chk_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  cov_sw: cover property (full_reset_pulse_r && sw_mode_r);
  cov_hw: cover property (full_reset_pulse_r && !sw_mode_r);
  cov_part: cover property (partial_reset_pulse_r);
endmodule // rscl_chk
bind rscl_top rscl_chk rscl_chk_i (.clk_sys, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
  .avs_response, .config_valid_r, .sw_mode_r, .range_code_r, .int_ref_en_r, .serial_if_r,
  .serial_one_wire_r, .full_reset_pulse_r, .partial_reset_pulse_r, .feat_per_chan_r,
  .feat_unified_r, .feat_full_seq_r, .feat_diag_r, .feat_reg_access_r, .feat_oversample_r,
  .feat_one_wire_r, .feat_two_wire_r);

/* File: bench/rscl_host.sv */
`timescale 1ns/1ps
// Host side: holds the reset pin low for a commanded time, then lets the straps go
module rscl_host (
  // Clock
  input  wire logic       clk_sys,
  // Commands from the bench
  input  wire logic       go,
  input  wire logic [7:0] low_cyc,
  input  wire logic [4:0] straps,
  // Pins toward the device, and busy back to the bench
  output reg        [1:0] range_strap_pins,
  output reg              reference_source_select,
  output reg              interface_type_select,
  output reg              serial_single_output_select,
  output reg              rst_pin_n,
  output reg              busy
);
  reg [7:0] cnt_r;
  initial begin
    {range_strap_pins, reference_source_select} = 3'h0;
    {interface_type_select, serial_single_output_select} = 2'h0;
    rst_pin_n = 1'h1;
    busy = 1'h0;
    cnt_r = 8'h00;
  end
  // Straps are only held a few cycles past the rise; after that they flip so a late sample shows
  always @(posedge clk_sys) begin
    if (go && !busy) begin
      {range_strap_pins, reference_source_select, interface_type_select,
       serial_single_output_select} <= straps;
      rst_pin_n <= 1'h0;
      cnt_r <= low_cyc;
      busy <= 1'h1;
    end else if (busy) begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01)
        rst_pin_n <= 1'h1;
      if (cnt_r == 8'hfc) begin
        {range_strap_pins, reference_source_select, interface_type_select,
         serial_single_output_select} <= ~{range_strap_pins, reference_source_select,
         interface_type_select, serial_single_output_select};
        busy <= 1'h0;
      end
    end
  end
endmodule // rscl_host

/* File: bench/tb_reset_strap_config_latch.sv */
`timescale 1ns/1ps
// Bench: strap rows through full resets, then bus, partial, short-gap and sys reset cases
module tb_reset_strap_config_latch;
  logic        clk_sys, sys_rst, go, avs_read, avs_write;
  logic [7:0]  low_cyc;
  logic [4:0]  straps, s;
  logic [9:0]  fe;
  logic [3:0]  avs_address, e;
  logic [31:0] avs_writedata, avs_readdata, rd, chan_range_r;
  logic [1:0]  avs_response, rsp, range_code_r, range_strap_pins, er;
  logic        avs_waitrequest, config_valid_r, sw_mode_r, int_ref_en_r, serial_if_r;
  logic        serial_one_wire_r, full_reset_pulse_r, partial_reset_pulse_r, feat_per_chan_r;
  logic        feat_unified_r, feat_seq_r, feat_full_seq_r, feat_burst_r, feat_oversample_r;
  logic        feat_diag_r, feat_one_wire_r, feat_two_wire_r, feat_reg_access_r, busy;
  logic        rst_pin_n, reference_source_select, interface_type_select;
  logic        serial_single_output_select;
  int          mismatches, n_compared, n_full, n_part;
  // Rows: range, ref, iface, single -> sw, int ref, serial, one-wire
  logic [8:0]  rows [5] = '{9'h07f, 9'h090, 9'h166, 9'h1b3, 9'h008};

  rscl_top #(.CNT_W(8)) rscl_top_i (.clk_sys, .sys_rst, .rst_pin_n, .range_strap_pins,
    .reference_source_select, .interface_type_select, .serial_single_output_select,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_response,
    .avs_waitrequest, .config_valid_r, .sw_mode_r, .range_code_r, .int_ref_en_r,
    .serial_if_r, .serial_one_wire_r, .chan_range_r, .full_reset_pulse_r,
    .partial_reset_pulse_r, .feat_per_chan_r, .feat_unified_r, .feat_seq_r, .feat_full_seq_r,
    .feat_burst_r, .feat_oversample_r, .feat_diag_r, .feat_one_wire_r, .feat_two_wire_r,
    .feat_reg_access_r);
  rscl_host rscl_host_i (.clk_sys, .go, .low_cyc, .straps, .range_strap_pins,
    .reference_source_select, .interface_type_select, .serial_single_output_select,
    .rst_pin_n, .busy);

  always #10 clk_sys = ~clk_sys;
  // Count reset events seen at the outputs
  always @(posedge clk_sys) begin
    if (full_reset_pulse_r === 1'h1)
      n_full <= n_full + 1;
    if (partial_reset_pulse_r === 1'h1)
      n_part <= n_part + 1;
  end

  task automatic end_sim;
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Reset pin pulse through the host; returns a few cycles after straps flip
  task automatic pin_reset(input logic [7:0] lc, input logic [4:0] st);
    int i;
    n_full = 0;
    n_part = 0;
    go <= 1'h1;
    low_cyc <= lc;
    straps <= st;
    @(posedge clk_sys);
    go <= 1'h0;
    @(negedge clk_sys);
    for (i = 0; i < 300 && busy !== 1'h0; i++)
      @(negedge clk_sys);
    if (i == 300) begin
      mismatches++;
      $display("mismatch at %0t: pin reset timeout", $time);
    end
    repeat (4) @(posedge clk_sys); // Synchroniser depth plus two
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic avs(input logic we, input logic [3:0] a, input logic [31:0] wd);
    int i;
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !we;
    avs_write <= we;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'h0)
        break;
    end
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (i == 50) begin
      mismatches++;
      $display("mismatch at %0t: bus timeout", $time);
    end
    @(posedge clk_sys);
  endtask

  initial begin
    {clk_sys, go, avs_read, avs_write, low_cyc, straps} = '0;
    {avs_address, avs_writedata} = '0;
    sys_rst = 1'h1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(posedge clk_sys);
    for (int k = 0; k < 5; k++) begin
      s = rows[k][8:4];
      e = rows[k][3:0];
      er = e[3] ? 2'h0 : (s[4:3] == 2'h3 ? 2'h3 : ~s[4:3]);
      pin_reset(8'h3e, s);
      check(n_full, 1, "full event");
      check({sw_mode_r, int_ref_en_r}, e[3:2], "mode and ref");
      check({serial_if_r, serial_one_wire_r}, e[1:0], "interface");
      check(range_code_r, er, "range");
      check({feat_reg_access_r, feat_oversample_r}, {e[3], e[3] | e[1]}, "feat");
      fe = {feat_reg_access_r, feat_two_wire_r, feat_one_wire_r, feat_diag_r, feat_oversample_r,
            feat_burst_r, feat_full_seq_r, feat_seq_r, feat_unified_r, feat_per_chan_r};
      check(fe[9:5], {e[3], e[1], e[1], e[3], e[3] | e[1]}, "features high");
      check(fe[4:0], {1'h1, e[3], 1'h1, ~e[3], e[3]}, "features low");
      avs(1'h0, 4'h0, 32'h0);
      check(rsp, e[3] ? 2'h0 : 2'h2, "status rsp");
      check(rd, e[3] ? {24'h0, 1'h0, e[0], e[1], e[2], 4'h3} : 32'h0, "status");
      check(chan_range_r, e[3] ? 32'h0 : {16{er}}, "channel ranges");
    end
    // Software mode from the last row: range register path and an unmapped place
    avs(1'h1, 4'h4, 32'h1234_abcd);
    check(rsp, 2'h0, "range write");
    avs(1'h0, 4'hc, 32'h0);
    check(rsp, 2'h2, "unmapped");
    check(chan_range_r, 32'h1234_abcd, "channel ranges from register");
    // Partial reset with changed straps keeps everything
    pin_reset(8'h0a, 5'h1f);
    check(n_part, 1, "partial event");
    check(n_full, 0, "no full on partial");
    check({sw_mode_r, int_ref_en_r, serial_if_r}, 3'h4, "kept");
    avs(1'h0, 4'h4, 32'h0);
    check(rd, 32'h1234_abcd, "range kept");
    // Low too long for partial, too short for full: nothing
    pin_reset(8'h28, 5'h1f);
    check(n_part, 0, "gap partial");
    check(n_full, 0, "gap full");
    // System reset in mid-run drops the capture, refuses the bus and fakes no partial-reset event
    sys_rst <= 1'h1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(posedge clk_sys);
    avs(1'h0, 4'h0, 32'h0);
    check({config_valid_r, rsp}, 3'h2, "after sys reset");
    @(posedge clk_sys);
    check(n_part, 0, "no event from sys reset");
    end_sim();
  end
endmodule // tb_reset_strap_config_latch

/* File: core/rscl_map.vh */
// How it works
// - Range strap pins sampled at full-reset release fix the working mode.
// - Range straps 00 select software mode; other patterns select hardware mode and range.
// - In software mode later range strap changes are ignored.
// - Mode stays fixed until the next full reset; host must fully reset to change.
// - Hardware mode refuses all register accesses; settings come from pins only.
// - Software mode takes interface and reference from straps, all else via registers.
// - Reference select pin sampled at full-reset release decides internal reference.
// - Later reference select changes ignored until the next full reset.
// - Captured reference select of one enables the internal reference.
// - Captured zero disables internal reference; host supplies external reference.
// - Interface type select sampled at full-reset release fixes interface type.
// - Captured interface select of zero enables the parallel interface.
// - Captured interface select of one selects the serial interface.
// - With serial chosen, single-output select picks one-wire or two-wire serial.
// - Interface and single-output selects ignored afterwards until next full reset.
// - Software mode enables every function but unified range; one-wire and two-wire only with serial.
// - Hardware mode disables per-channel, full sequencer, diagnostics, registers; one range.
// - Range code 00 defers to register, 01 2.5 V, 10 5 V, 11 10 V.
// - Reset pin low at least 1.2 us is a full reset recapturing straps.
// - Reset pin low 40 ns to 500 ns is a partial reset, no recapture.
`ifndef RSCL_MAP_VH
`define RSCL_MAP_VH

// Register byte offsets
`define RSCL_OFS_STATUS   4'h0
`define RSCL_OFS_RANGE    4'h4
`define RSCL_OFS_FEAT     4'h8

// Status register fields
`define RSCL_ST_VALID     0
`define RSCL_ST_SWMODE    1
`define RSCL_ST_RNG_LO    2
`define RSCL_ST_RNG_HI    3
`define RSCL_ST_INTREF    4
`define RSCL_ST_SERIAL    5
`define RSCL_ST_ONEWIRE   6
`define RSCL_ST_INRST     7

// Feature register fields
`define RSCL_FT_PERCHAN   0
`define RSCL_FT_UNIFIED   1
`define RSCL_FT_SEQ       2
`define RSCL_FT_FULLSEQ   3
`define RSCL_FT_BURST     4
`define RSCL_FT_OSMP      5
`define RSCL_FT_DIAG      6
`define RSCL_FT_1WIRE     7
`define RSCL_FT_2WIRE     8
`define RSCL_FT_REGACC    9

// Reset values
`define RSCL_RANGE_RST    32'h0000_0000
`define RSCL_RNG_RST      2'h3

// Range strap codes
`define RSCL_RNG_SW       2'h0
`define RSCL_RNG_2V5      2'h1
`define RSCL_RNG_5V       2'h2
`define RSCL_RNG_10V      2'h3

// Avalon responses
`define RSCL_RSP_OK       2'h0
`define RSCL_RSP_ERR      2'h2

// Timing, in ns, and clock rate
`define RSCL_CLK_MHZ      50
`define RSCL_FULL_NS      1200
`define RSCL_PART_MIN_NS  40
`define RSCL_PART_MAX_NS  500

`endif

/* File: core/rscl_sync.v */
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of pin levels
module rscl_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         sys_rst,
  // Asynchronous levels in
  input  wire [W-1:0] async_in,
  // Synchronised levels out
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_r;
  reg [W-1:0] stab_r;

  // First stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= {W{1'b0}};
      stab_r <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      stab_r <= meta_r;
    end
  end

  assign sync_out = stab_r;

endmodule // rscl_sync

/* File: core/rscl_top.v */
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "rscl_map.vh"
// Strap capture at full-reset release, feature gating and register slave
module rscl_top #(
  parameter CNT_W = 8
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // Device reset pin, active low
  input  wire        rst_pin_n,
  // Strap pins
  input  wire [1:0]  range_strap_pins,
  input  wire        reference_source_select,
  input  wire        interface_type_select,
  input  wire        serial_single_output_select,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg  [1:0]  avs_response,
  output reg         avs_waitrequest,
  // Captured configuration
  output reg         config_valid_r,
  output reg         sw_mode_r,
  output reg  [1:0]  range_code_r,
  output reg         int_ref_en_r,
  output reg         serial_if_r,
  output reg         serial_one_wire_r,
  output reg  [31:0] chan_range_r,
  // Reset events, one-cycle pulses
  output reg         full_reset_pulse_r,
  output reg         partial_reset_pulse_r,
  // Feature enables
  output reg         feat_per_chan_r,
  output reg         feat_unified_r,
  output reg         feat_seq_r,
  output reg         feat_full_seq_r,
  output reg         feat_burst_r,
  output reg         feat_oversample_r,
  output reg         feat_diag_r,
  output reg         feat_one_wire_r,
  output reg         feat_two_wire_r,
  output reg         feat_reg_access_r
);

  // Least times round up, longest times round down
  function integer cyc_ceil;
    input integer ns;
    begin
      cyc_ceil = (ns * `RSCL_CLK_MHZ + 999) / 1000;
      if (cyc_ceil < 1) begin
        cyc_ceil = 1;
      end
    end
  endfunction

  function integer cyc_floor;
    input integer ns;
    begin
      cyc_floor = (ns * `RSCL_CLK_MHZ) / 1000;
      if (cyc_floor < 1) begin
        cyc_floor = 1;
      end
    end
  endfunction

  localparam integer FULL_CYC_I  = cyc_ceil(`RSCL_FULL_NS);
  localparam integer PMIN_CYC_I  = cyc_ceil(`RSCL_PART_MIN_NS);
  localparam integer PMAX_CYC_I  = cyc_floor(`RSCL_PART_MAX_NS);
  localparam [CNT_W-1:0] FULL_CYC = FULL_CYC_I[CNT_W-1:0];
  localparam [CNT_W-1:0] PMIN_CYC = PMIN_CYC_I[CNT_W-1:0];
  localparam [CNT_W-1:0] PMAX_CYC = PMAX_CYC_I[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};

  // Bus handshake states
  localparam [1:0] BS_IDLE = 2'b01;
  localparam [1:0] BS_ACK  = 2'b10;

  // Synchronised pins
  wire [5:0] pins_s;
  wire       rst_s;
  wire [1:0] rng_s;
  wire       ref_s;
  wire       ifc_s;
  wire       one_s;

  // Pin enters inverted so a cleared synchroniser reads as released, not as a short pulse
  rscl_sync #(
    .W (6)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in ({~rst_pin_n, range_strap_pins, reference_source_select,
                interface_type_select, serial_single_output_select}),
    .sync_out (pins_s)
  );

  assign rst_s = ~pins_s[5];
  assign rng_s = pins_s[4:3];
  assign ref_s = pins_s[2];
  assign ifc_s = pins_s[1];
  assign one_s = pins_s[0];

  // Pulse-length measurement
  reg             rst_prev_r;
  reg [CNT_W-1:0] low_cnt_r;
  wire            rise_w;
  wire            full_rel_w;
  wire            part_rel_w;

  assign rise_w     = rst_s & ~rst_prev_r;
  // Counter saturates, so very long resets still classify as full
  assign full_rel_w = rise_w & (low_cnt_r >= FULL_CYC);
  // A pulse between the partial and full windows is treated as neither
  assign part_rel_w = rise_w & (low_cnt_r >= PMIN_CYC) & (low_cnt_r <= PMAX_CYC);

  // Count synchronised low time of the reset pin
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rst_prev_r <= 1'b1;
      low_cnt_r  <= {CNT_W{1'b0}};
    end else begin
      rst_prev_r <= rst_s;
      if (rst_s) begin
        low_cnt_r <= {CNT_W{1'b0}};
      end else if (low_cnt_r != CNT_MAX) begin
        low_cnt_r <= low_cnt_r + 1'b1;
      end
    end
  end

  // Reset event pulses
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      full_reset_pulse_r    <= 1'b0;
      partial_reset_pulse_r <= 1'b0;
    end else begin
      full_reset_pulse_r    <= full_rel_w;
      partial_reset_pulse_r <= part_rel_w;
    end
  end

  // Strap latches load only in the full-release cycle
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      config_valid_r    <= 1'b0;
      sw_mode_r         <= 1'b0;
      int_ref_en_r      <= 1'b0;
      serial_if_r       <= 1'b0;
      serial_one_wire_r <= 1'b0;
    end else if (full_rel_w) begin
      config_valid_r    <= 1'b1;
      sw_mode_r         <= (rng_s == `RSCL_RNG_SW);
      int_ref_en_r      <= ref_s;
      serial_if_r       <= ifc_s;
      serial_one_wire_r <= ifc_s & one_s;
    end
    // Otherwise hold: later pin changes do nothing until a full reset
  end

  // Range code: fixed to register control in software mode, live pins in hardware mode, reset value 11 until capture
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      range_code_r <= `RSCL_RNG_RST;
    end else if (full_rel_w) begin
      range_code_r <= rng_s;
    end else if (config_valid_r && !sw_mode_r && rng_s != `RSCL_RNG_SW) begin
      // Straps going to 00 in hardware mode cannot switch mode, so keep last range
      range_code_r <= rng_s;
    end
    // Software mode ignores the range straps
  end

  // Feature matrix per captured mode and interface
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      feat_per_chan_r   <= 1'b0;
      feat_unified_r    <= 1'b0;
      feat_seq_r        <= 1'b0;
      feat_full_seq_r   <= 1'b0;
      feat_burst_r      <= 1'b0;
      feat_oversample_r <= 1'b0;
      feat_diag_r       <= 1'b0;
      feat_one_wire_r   <= 1'b0;
      feat_two_wire_r   <= 1'b0;
      feat_reg_access_r <= 1'b0;
    end else begin
      feat_per_chan_r   <= config_valid_r & sw_mode_r;
      feat_unified_r    <= config_valid_r & ~sw_mode_r;
      feat_seq_r        <= config_valid_r;
      feat_full_seq_r   <= config_valid_r & sw_mode_r;
      feat_burst_r      <= config_valid_r;
      feat_oversample_r <= config_valid_r & (sw_mode_r | serial_if_r);
      feat_diag_r       <= config_valid_r & sw_mode_r;
      feat_one_wire_r   <= config_valid_r & serial_if_r;
      feat_two_wire_r   <= config_valid_r & serial_if_r;
      feat_reg_access_r <= config_valid_r & sw_mode_r;
    end
  end

  // Bus slave
  reg  [1:0]  bus_st_r;
  reg  [31:0] range_reg_r;
  wire        req_w;
  wire        allow_w;
  wire        hit_st_w;
  wire        hit_rng_w;
  wire        hit_ft_w;
  reg  [31:0] rd_nxt;
  reg  [1:0]  rsp_nxt;
  wire [31:0] status_w;
  wire [31:0] feat_w;

  assign req_w   = avs_read | avs_write;
  // Register access only once software mode has been captured
  assign allow_w = config_valid_r & sw_mode_r;

  assign hit_st_w  = (avs_address == `RSCL_OFS_STATUS);
  assign hit_rng_w = (avs_address == `RSCL_OFS_RANGE);
  assign hit_ft_w  = (avs_address == `RSCL_OFS_FEAT);

  assign status_w = {24'h00_0000, ~rst_s, serial_one_wire_r, serial_if_r,
                     int_ref_en_r, range_code_r, sw_mode_r, config_valid_r};

  assign feat_w = {22'h00_0000, feat_reg_access_r, feat_two_wire_r,
                   feat_one_wire_r, feat_diag_r, feat_oversample_r,
                   feat_burst_r, feat_full_seq_r, feat_seq_r,
                   feat_unified_r, feat_per_chan_r};

  // Read decode and response
  always @* begin
    rd_nxt  = 32'h0000_0000;
    rsp_nxt = `RSCL_RSP_OK;
    if (!allow_w) begin
      rsp_nxt = `RSCL_RSP_ERR;
    end else if (hit_st_w) begin
      rd_nxt = status_w;
      if (avs_write) begin
        rsp_nxt = `RSCL_RSP_ERR;
      end
    end else if (hit_rng_w) begin
      rd_nxt = range_reg_r;
    end else if (hit_ft_w) begin
      rd_nxt = feat_w;
      if (avs_write) begin
        rsp_nxt = `RSCL_RSP_ERR;
      end
    end else begin
      rsp_nxt = `RSCL_RSP_ERR;
    end
    if (avs_write) begin
      rd_nxt = 32'h0000_0000;
    end
  end

  // One wait state: answer comes one cycle after the request is seen
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_st_r        <= BS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      avs_response    <= `RSCL_RSP_OK;
    end else begin
      case (bus_st_r)
        BS_IDLE: begin
          if (req_w) begin
            bus_st_r        <= BS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rd_nxt;
            avs_response    <= rsp_nxt;
          end
        end
        BS_ACK: begin
          bus_st_r        <= BS_IDLE;
          avs_waitrequest <= 1'b1;
          avs_readdata    <= 32'h0000_0000;
          avs_response    <= `RSCL_RSP_OK;
        end
        default: begin
          bus_st_r        <= BS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Range register: cleared by full reset, untouched by partial reset;
  // a write lands at the ack edge, where the master sees waitrequest low
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      range_reg_r <= `RSCL_RANGE_RST;
    end else if (full_rel_w) begin
      range_reg_r <= `RSCL_RANGE_RST;
    end else if (bus_st_r == BS_ACK && avs_write && hit_rng_w && allow_w) begin
      range_reg_r <= avs_writedata;
    end
  end

  // Per-channel ranges: register in software mode, one strap range in hardware mode, cleared until capture
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      chan_range_r <= `RSCL_RANGE_RST;
    end else if (!config_valid_r) begin
      chan_range_r <= `RSCL_RANGE_RST;
    end else if (sw_mode_r) begin
      chan_range_r <= range_reg_r;
    end else begin
      chan_range_r <= {16{range_code_r}};
    end
  end

endmodule // rscl_top
